// *** src/e1ri_top.v ***
// e1 receive slip and auxiliary pattern interrupt block, axi4-lite slave
//
// Function
// - A buffer write while full drops one whole frame and flags full.
// - A buffer read while empty repeats one whole frame and flags empty.
// - Slip enable bit 2 gates the full interrupt, read/write, reset 0.
// - Slip enable bit 1 gates the empty interrupt, read/write, reset 0.
// - Slip enable bit 0 gates the slip interrupt on either slip, reset 0.
// - Loop code status bit 7 shows the 101010 pattern is seen now.
// - Loop code status bit 6 latches start and end of the pattern.
// - Loop code status event bits clear when software reads them.
// - Frame lock without multiframe lock for 400 ms marks a non-crc-4 end.
// - Loop code status bit 5 shows interworking and both its onset and its end flag bit 4.
// - A change raises the interrupt only when its enable bit is set.
// - Interworking state only holds while annex b mode is enabled.
// - Slip status bit 0 latches a slip, clears on read, resets to 0.
// - Loop code enable bit 4 gates the interworking change interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "e1ri_defines.vh"

module e1ri_top #(
  parameter ADDR_W   = 16,
  parameter IW_LIMIT = `E1RI_IW_CYCLES
) (
  input  wire              I_CLK,
  input  wire              I_RST_N,
  input  wire [ADDR_W-1:0] I_AWADDR,
  input  wire              I_AWVALID,
  output wire              O_AWREADY,
  input  wire [31:0]       I_WDATA,
  input  wire [3:0]        I_WSTRB,
  input  wire              I_WVALID,
  output wire              O_WREADY,
  output wire [1:0]        O_BRESP,
  output wire              O_BVALID,
  input  wire              I_BREADY,
  input  wire [ADDR_W-1:0] I_ARADDR,
  input  wire              I_ARVALID,
  output wire              O_ARREADY,
  output wire [31:0]       O_RDATA,
  output wire [1:0]        O_RRESP,
  output wire              O_RVALID,
  input  wire              I_RREADY,
  input  wire              I_SB_WRITE,
  input  wire              I_SB_READ,
  input  wire              I_SB_FULL,
  input  wire              I_SB_EMPTY,
  input  wire              I_ALT_PATTERN,
  input  wire              I_BFA_PRESENT,
  input  wire              I_MF_ALIGNED,
  output wire              O_FRAME_DELETE,
  output wire              O_FRAME_REPEAT,
  output wire              O_IRQ
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  reg  [2:0]        slip_en_q;
  reg  [2:0]        slip_en_d;
  reg  [2:0]        slip_sts_q;
  reg  [2:0]        slip_sts_d;
  reg  [1:0]        lc_en_q;      // [1] alt change, [0] interworking
  reg  [1:0]        lc_en_d;
  reg  [1:0]        lc_sts_q;     // [1] alt change, [0] interworking
  reg  [1:0]        lc_sts_d;
  reg               annex_b_q;
  reg               annex_b_d;
  reg               alt_now_q;
  reg               iw_prev_q;
  reg               del_q;
  reg               rep_q;
  reg               irq_q;
  reg               irq_d;

  reg               awready_q;
  reg               awready_d;
  reg               aw_held_q;
  reg               aw_held_d;
  reg  [ADDR_W-1:0] awaddr_q;
  reg  [ADDR_W-1:0] awaddr_d;
  reg               wready_q;
  reg               wready_d;
  reg               w_held_q;
  reg               w_held_d;
  reg  [31:0]       wdata_q;
  reg  [31:0]       wdata_d;
  reg  [3:0]        wstrb_q;
  reg  [3:0]        wstrb_d;
  reg               bvalid_q;
  reg               bvalid_d;
  reg  [1:0]        bresp_q;
  reg  [1:0]        bresp_d;
  reg               arready_q;
  reg               arready_d;
  reg               rvalid_q;
  reg               rvalid_d;
  reg  [31:0]       rdata_q;
  reg  [31:0]       rdata_d;
  reg  [1:0]        rresp_q;
  reg  [1:0]        rresp_d;

  wire              aw_take;
  wire              w_take;
  wire              ar_take;
  wire              do_write;
  wire [ADDR_W-1:0] wr_addr;
  wire [31:0]       wr_data;
  wire [3:0]        wr_strb;
  wire [13:0]       wr_idx;
  wire [13:0]       rd_idx;
  wire              wr_hi_zero;
  wire              rd_hi_zero;
  wire              full_evt;
  wire              empty_evt;
  wire              alt_chg_evt;
  wire              iw_now;
  wire              iw_chg_evt;
  wire [2:0]        slip_set;
  wire [1:0]        lc_set;
  wire              rd_slip_sts;
  wire              rd_lc_sts;
  wire [7:0]        slip_sts_rd;
  wire [7:0]        slip_en_rd;
  wire [7:0]        lc_sts_rd;
  wire [7:0]        lc_en_rd;
  wire [7:0]        fc_rd;

  ////////////////////////////////////////////////////////////////////////
  // framer events
  // overfill drops a frame
  assign full_evt    = I_SB_WRITE & I_SB_FULL;
  assign empty_evt   = I_SB_READ & I_SB_EMPTY;
  assign alt_chg_evt = I_ALT_PATTERN ^ alt_now_q;
  assign iw_chg_evt  = iw_now ^ iw_prev_q;

  // slip bit set by either slip
  assign slip_set = {full_evt, empty_evt, full_evt | empty_evt};
  assign lc_set   = {alt_chg_evt, iw_chg_evt};

  // interworking detector, runs off the annex b mode bit
  e1ri_iw_timer #(
    .LIMIT         (IW_LIMIT)
  ) u_iw (
    .i_clk         (I_CLK),
    .i_rst_n       (I_RST_N),
    .i_annex_b     (annex_b_q),
    .i_bfa_present (I_BFA_PRESENT),
    .i_mf_aligned  (I_MF_ALIGNED),
    .o_established (iw_now)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus handshakes
  assign aw_take  = I_AWVALID & awready_q;
  assign w_take   = I_WVALID & wready_q;
  assign ar_take  = I_ARVALID & arready_q;
  assign wr_addr  = aw_take ? I_AWADDR : awaddr_q;
  assign wr_data  = w_take ? I_WDATA : wdata_q;
  assign wr_strb  = w_take ? I_WSTRB : wstrb_q;
  // a write commits once both halves are in, in either order
  assign do_write = (aw_held_q | aw_take) & (w_held_q | w_take) & ~bvalid_q;

  // word index and check that nothing above the map is set
  assign wr_idx     = wr_addr[15:2];
  assign rd_idx     = I_ARADDR[15:2];
  assign wr_hi_zero = (wr_addr >> 16) == {ADDR_W{1'b0}};
  assign rd_hi_zero = (I_ARADDR >> 16) == {ADDR_W{1'b0}};

  // read decode used for the clear-on-read side effect
  assign rd_slip_sts = ar_take & rd_hi_zero & (rd_idx == `E1RI_IDX_SLIP_STS);
  assign rd_lc_sts   = ar_take & rd_hi_zero & (rd_idx == `E1RI_IDX_LC_STS);

  // read images; unused bits read as zero
  assign slip_sts_rd = {5'h00, slip_sts_q};
  assign slip_en_rd  = {5'h00, slip_en_q};
  assign lc_sts_rd   = {alt_now_q, lc_sts_q[1], iw_now, lc_sts_q[0], 4'h0};
  assign lc_en_rd    = {1'b0, lc_en_q[1], 1'b0, lc_en_q[0], 4'h0};
  assign fc_rd       = {7'h00, annex_b_q};

  ////////////////////////////////////////////////////////////////////////
  // write channel
  always @* begin
    aw_held_d = aw_held_q | aw_take;
    w_held_d  = w_held_q | w_take;
    awaddr_d  = aw_take ? I_AWADDR : awaddr_q;
    wdata_d   = w_take ? I_WDATA : wdata_q;
    wstrb_d   = w_take ? I_WSTRB : wstrb_q;
    bvalid_d  = bvalid_q & ~I_BREADY;
    bresp_d   = bresp_q;
    slip_en_d = slip_en_q;
    lc_en_d   = lc_en_q;
    annex_b_d = annex_b_q;
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = `E1RI_RESP_OKAY;
      if (!wr_hi_zero) begin
        bresp_d = `E1RI_RESP_SLVERR;
      end else begin
        case (wr_idx)
          `E1RI_IDX_SLIP_EN: begin
            if (wr_strb[0]) begin
              slip_en_d = wr_data[2:0];
            end
          end
          `E1RI_IDX_LC_EN: begin
            if (wr_strb[0]) begin
              lc_en_d = {wr_data[`E1RI_LC_ALT_CHG_BIT],
                         wr_data[`E1RI_LC_IW_CHG_BIT]};
            end
          end
          `E1RI_IDX_FRM_CTRL: begin
            if (wr_strb[0]) begin
              annex_b_d = wr_data[`E1RI_FC_ANNEX_B_BIT];
            end
          end
          // status registers ignore writes; reads clear them
          `E1RI_IDX_SLIP_STS: bresp_d = `E1RI_RESP_OKAY;
          `E1RI_IDX_LC_STS:   bresp_d = `E1RI_RESP_OKAY;
          default:            bresp_d = `E1RI_RESP_SLVERR;
        endcase
      end
    end
    // no new halves are taken while a response is pending
    awready_d = ~aw_held_d & ~bvalid_d;
    wready_d  = ~w_held_d & ~bvalid_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // read channel
  always @* begin
    rvalid_d = rvalid_q & ~I_RREADY;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rresp_d  = `E1RI_RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      if (!rd_hi_zero) begin
        rresp_d = `E1RI_RESP_SLVERR;
      end else begin
        case (rd_idx)
          `E1RI_IDX_SLIP_STS: rdata_d = {24'h00_0000, slip_sts_rd};
          `E1RI_IDX_SLIP_EN:  rdata_d = {24'h00_0000, slip_en_rd};
          `E1RI_IDX_LC_STS:   rdata_d = {24'h00_0000, lc_sts_rd};
          `E1RI_IDX_LC_EN:    rdata_d = {24'h00_0000, lc_en_rd};
          `E1RI_IDX_FRM_CTRL: rdata_d = {24'h00_0000, fc_rd};
          default:            rresp_d = `E1RI_RESP_SLVERR;
        endcase
      end
    end
    // one read at a time: address closes until the data is taken
    arready_d = ~rvalid_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status and interrupt request
  // a set in the cycle of the clearing read wins, so no event is lost
  always @* begin
    slip_sts_d = slip_sts_q;
    lc_sts_d   = lc_sts_q;
    if (rd_slip_sts) begin
      slip_sts_d = `E1RI_RST_STS;
    end
    if (rd_lc_sts) begin
      lc_sts_d = 2'h0;
    end
    slip_sts_d = slip_sts_d | slip_set;
    lc_sts_d   = lc_sts_d | lc_set;
    irq_d = |(slip_sts_d & slip_en_d) | |(lc_sts_d & lc_en_d);
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      slip_en_q  <= `E1RI_RST_SLIP_EN;
      slip_sts_q <= `E1RI_RST_STS;
      lc_en_q    <= `E1RI_RST_LC_EN;
      lc_sts_q   <= 2'h0;
      annex_b_q  <= 1'b0;
      alt_now_q  <= 1'b0;
      iw_prev_q  <= 1'b0;
      del_q      <= 1'b0;
      rep_q      <= 1'b0;
      irq_q      <= 1'b0;
      awready_q  <= 1'b0;
      aw_held_q  <= 1'b0;
      awaddr_q   <= {ADDR_W{1'b0}};
      wready_q   <= 1'b0;
      w_held_q   <= 1'b0;
      wdata_q    <= 32'h0000_0000;
      wstrb_q    <= 4'h0;
      bvalid_q   <= 1'b0;
      bresp_q    <= `E1RI_RESP_OKAY;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= `E1RI_RESP_OKAY;
    end else begin
      slip_en_q  <= slip_en_d;
      slip_sts_q <= slip_sts_d;
      lc_en_q    <= lc_en_d;
      lc_sts_q   <= lc_sts_d;
      annex_b_q  <= annex_b_d;
      alt_now_q  <= I_ALT_PATTERN;
      iw_prev_q  <= iw_now;
      del_q      <= full_evt;
      rep_q      <= empty_evt;
      irq_q      <= irq_d;
      awready_q  <= awready_d;
      aw_held_q  <= aw_held_d;
      awaddr_q   <= awaddr_d;
      wready_q   <= wready_d;
      w_held_q   <= w_held_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      arready_q  <= arready_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops
  assign O_AWREADY      = awready_q;
  assign O_WREADY       = wready_q;
  assign O_BVALID       = bvalid_q;
  assign O_BRESP        = bresp_q;
  assign O_ARREADY      = arready_q;
  assign O_RVALID       = rvalid_q;
  assign O_RDATA        = rdata_q;
  assign O_RRESP        = rresp_q;
  assign O_FRAME_DELETE = del_q;
  assign O_FRAME_REPEAT = rep_q;
  assign O_IRQ          = irq_q;

endmodule

`default_nettype wire

// *** src/e1ri_defines.vh ***
// register map, field positions and timing for the e1 rx interrupt block
`ifndef E1RI_DEFINES_VH
`define E1RI_DEFINES_VH

// register indices; byte address is four times the index
`define E1RI_IDX_SLIP_STS     14'h0b08
`define E1RI_IDX_SLIP_EN      14'h0b09
`define E1RI_IDX_LC_STS       14'h0b0a
`define E1RI_IDX_LC_EN        14'h0b0b
`define E1RI_IDX_FRM_CTRL     14'h0107

// slip status and slip enable fields
`define E1RI_SLIP_FULL_BIT    2
`define E1RI_SLIP_EMPTY_BIT   1
`define E1RI_SLIP_SLIP_BIT    0

// loop code status and enable fields
`define E1RI_LC_ALT_STAT_BIT  7
`define E1RI_LC_ALT_CHG_BIT   6
`define E1RI_LC_IW_STAT_BIT   5
`define E1RI_LC_IW_CHG_BIT    4

// framing control field
`define E1RI_FC_ANNEX_B_BIT   0

// reset values
`define E1RI_RST_SLIP_EN      3'h0
`define E1RI_RST_LC_EN        2'h0
`define E1RI_RST_STS          3'h0

// bus answers
`define E1RI_RESP_OKAY        2'h0
`define E1RI_RESP_SLVERR      2'h2

// interworking timeout: 400 ms at a 10 ns clock
`define E1RI_IW_TIME_MS       400
`define E1RI_CLK_PERIOD_NS    10
`define E1RI_IW_CYCLES        ((`E1RI_IW_TIME_MS * 1000000) / `E1RI_CLK_PERIOD_NS)

`endif

// *** src/e1ri_iw_timer.v ***
// crc-4 to non-crc-4 interworking detector with its 400 ms timer
`timescale 1ns/1ps
`default_nettype none

module e1ri_iw_timer #(
  parameter LIMIT = 40000000
) (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire       i_annex_b,
  input  wire       i_bfa_present,
  input  wire       i_mf_aligned,
  output wire       o_established
);

  reg  [31:0] cnt_q;
  reg  [31:0] cnt_d;
  reg         est_q;
  reg         est_d;
  wire        hunting;

  // only hunt while annex b is on, frames align and multiframes do not
  assign hunting = i_annex_b & i_bfa_present & ~i_mf_aligned;

  ////////////////////////////////////////////////////////////////////////
  // timer and state
  always @* begin
    cnt_d = cnt_q;
    est_d = est_q;
    if (!i_annex_b) begin
      cnt_d = 32'h0000_0000;
      est_d = 1'b0;
    end else if (i_mf_aligned) begin
      // far end turned out crc-4 capable after all
      cnt_d = 32'h0000_0000;
      est_d = 1'b0;
    end else if (hunting && !est_q) begin
      if (cnt_q >= LIMIT - 1) begin
        est_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 32'h0000_0001;
      end
    end else if (!i_bfa_present) begin
      // losing basic alignment restarts the window
      cnt_d = 32'h0000_0000;
    end
  end

  // registers
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q <= 32'h0000_0000;
      est_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      est_q <= est_d;
    end
  end

  assign o_established = est_q;

endmodule

`default_nettype wire

// *** testbench/e1ri_chk.sv ***
// port checker for the e1 rx interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "e1ri_defines.vh"
module e1ri_chk #(
  parameter ADDR_W = 16
) (
  input wire logic              I_CLK,
  input wire logic              I_RST_N,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic              I_ARVALID,
  input wire logic              O_ARREADY,
  input wire logic [31:0]       O_RDATA,
  input wire logic [1:0]        O_RRESP,
  input wire logic              O_RVALID,
  input wire logic              I_WVALID,
  input wire logic              O_WREADY,
  input wire logic              I_SB_WRITE,
  input wire logic              I_SB_READ,
  input wire logic              I_SB_FULL,
  input wire logic              I_SB_EMPTY,
  input wire logic              I_ALT_PATTERN,
  input wire logic              I_MF_ALIGNED,
  input wire logic              O_FRAME_DELETE,
  input wire logic              O_FRAME_REPEAT,
  input wire logic              O_IRQ
);
  logic [13:0] rd_idx_q;
  logic [2:0]  mf_run_q;
  wire         rd_lc    = (rd_idx_q == `E1RI_IDX_LC_STS);
  // qualified events that the properties look back at
  wire         full_wr  = I_SB_WRITE && I_SB_FULL;
  wire         empty_rd = I_SB_READ && I_SB_EMPTY;
  wire         ar_hs    = I_ARVALID && O_ARREADY;
  wire         w_hs     = I_WVALID && O_WREADY;
  ////////////////////////////////////////////////////////////
  // index of the read in flight, and how long multiframe lock has held
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      rd_idx_q <= 14'h0000;
      mf_run_q <= 3'h0;
    end else begin
      if (I_ARVALID && O_ARREADY)
        rd_idx_q <= I_ARADDR[15:2];
      if (!I_MF_ALIGNED)
        mf_run_q <= 3'h0;
      else if (mf_run_q != 3'h7)
        mf_run_q <= mf_run_q + 3'h1;
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // slip actions and their only causes
  a_full_drops: assert property (full_wr |=> O_FRAME_DELETE)
    else $error("no frame drop after write while full");
  a_empty_repeats: assert property (empty_rd |=> O_FRAME_REPEAT)
    else $error("no frame repeat after read while empty");
  a_drop_cause: assert property (O_FRAME_DELETE |-> $past(full_wr))
    else $error("frame drop without cause");
  a_repeat_cause: assert property (O_FRAME_REPEAT |-> $past(empty_rd))
    else $error("frame repeat without cause");
  // request drops only after a read or an enable write
  a_irq_fall_cause: assert property ($fell(O_IRQ) |-> $past(ar_hs)
    || $past(w_hs) || $past(w_hs, 2))
    else $error("interrupt dropped without a read or write");
  a_alt_state_read: assert property ($rose(O_RVALID) && rd_lc
    && $past(I_ALT_PATTERN, 3) == $past(I_ALT_PATTERN)
    && $past(I_ALT_PATTERN, 2) == $past(I_ALT_PATTERN)
    |-> O_RDATA[7] == $past(I_ALT_PATTERN))
    else $error("pattern state bit wrong");
  a_iw_mf_clears: assert property ($rose(O_RVALID) && rd_lc
    && mf_run_q == 3'h7 |-> !O_RDATA[5])
    else $error("interworking shown while multiframe locked");
  a_slverr_zero: assert property ($rose(O_RVALID) && O_RRESP == `E1RI_RESP_SLVERR
    |-> O_RDATA == 32'h0000_0000)
    else $error("error read returned data");
  a_upper_zero: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h00_0000)
    else $error("read data above bit 7 not zero");
  c_drop: cover property (O_FRAME_DELETE);
  c_repeat: cover property (O_FRAME_REPEAT);
  c_irq: cover property ($rose(O_IRQ));
endmodule
bind e1ri_top e1ri_chk #(.ADDR_W(ADDR_W)) i_chk (
  .I_CLK, .I_RST_N, .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA, .O_RRESP,
  .O_RVALID, .I_WVALID, .O_WREADY, .I_SB_WRITE, .I_SB_READ, .I_SB_FULL,
  .I_SB_EMPTY, .I_ALT_PATTERN, .I_MF_ALIGNED, .O_FRAME_DELETE,
  .O_FRAME_REPEAT, .O_IRQ);
`default_nettype wire

// *** testbench/e1ri_host.sv ***
// axi4-lite host model driving the register bus
`timescale 1ns/1ps
`default_nettype none
module e1ri_host (
  input  wire logic        i_clk,
  output logic      [15:0] o_awaddr,
  output logic             o_awvalid,
  input  wire logic        i_awready,
  output logic      [31:0] o_wdata,
  output logic      [3:0]  o_wstrb,
  output logic             o_wvalid,
  input  wire logic        i_wready,
  input  wire logic [1:0]  i_bresp,
  input  wire logic        i_bvalid,
  output logic             o_bready,
  output logic      [15:0] o_araddr,
  output logic             o_arvalid,
  input  wire logic        i_arready,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp,
  input  wire logic        i_rvalid,
  output logic             o_rready
);
  ////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    {o_awaddr, o_awvalid, o_wdata, o_wvalid, o_bready} = '0;
    {o_araddr, o_arvalid, o_rready} = '0;
    o_wstrb = 4'hf;
  end
  // both halves offered together; each dropped once its own ready is seen
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    o_awaddr  <= a;
    o_wdata   <= {24'h00_0000, d};
    o_awvalid <= 1'b1;
    o_wvalid  <= 1'b1;
    o_bready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_awvalid && i_awready)
        o_awvalid <= 1'b0;
      if (o_wvalid && i_wready)
        o_wvalid <= 1'b0;
    end while (!i_bvalid);
    r = i_bresp;
    o_bready <= 1'b0;
    @(posedge i_clk);
  endtask
  // the trailing edge keeps two calls from touching rready in one step
  task automatic rd(input logic [15:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    o_araddr  <= a;
    o_arvalid <= 1'b1;
    o_rready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_arvalid && i_arready)
        o_arvalid <= 1'b0;
    end while (!i_rvalid);
    d = i_rdata;
    r = i_rresp;
    o_rready <= 1'b0;
    @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the e1 rx interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "e1ri_defines.vh"
`define E1RI_CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); \
  end \
end
module testbench;
  localparam logic [15:0] A_SSTS = {`E1RI_IDX_SLIP_STS, 2'b00};
  localparam logic [15:0] A_SEN  = {`E1RI_IDX_SLIP_EN, 2'b00};
  localparam logic [15:0] A_LSTS = {`E1RI_IDX_LC_STS, 2'b00};
  localparam logic [15:0] A_LEN  = {`E1RI_IDX_LC_EN, 2'b00};
  localparam logic [15:0] A_FC   = {`E1RI_IDX_FRM_CTRL, 2'b00};
  typedef struct packed {
    logic       wr, rd, full, empty;
    logic [2:0] en;
    logic [7:0] sts;
    logic       irq;
  } e1ri_row_t;
  e1ri_row_t   rows [7];
  int          err_total = 0;
  int          comparisons = 0;
  logic        clk, rst_n, sb_wr, sb_rd, sb_full, sb_empty, alt, bfa, mf;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, frm_del, frm_rep, irq;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  ////////////////////////////////////////////////////////////
  e1ri_top #(.ADDR_W(16), .IW_LIMIT(20)) i_dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_SB_WRITE(sb_wr), .I_SB_READ(sb_rd), .I_SB_FULL(sb_full),
    .I_SB_EMPTY(sb_empty), .I_ALT_PATTERN(alt), .I_BFA_PRESENT(bfa),
    .I_MF_ALIGNED(mf), .O_FRAME_DELETE(frm_del),
    .O_FRAME_REPEAT(frm_rep), .O_IRQ(irq));
  e1ri_host i_host (
    .i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
    .i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb),
    .o_wvalid(wvalid), .i_wready(wready), .i_bresp(bresp),
    .i_bvalid(bvalid), .o_bready(bready), .o_araddr(araddr),
    .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata),
    .i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready));
  // clock and a watchdog far beyond the expected run length
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    final_report();
  end
  task automatic final_report();
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // slip rows: event, enables, expected status and request
  initial begin
    {rst_n, sb_wr, sb_rd, sb_full, sb_empty, alt, bfa, mf} = '0;
    rows = '{'{1, 0, 1, 0, 3'h0, 8'h05, 0}, '{0, 1, 0, 1, 3'h2, 8'h03, 1},
             '{1, 0, 0, 0, 3'h7, 8'h00, 0}, '{1, 0, 1, 0, 3'h4, 8'h05, 1},
             '{0, 1, 0, 1, 3'h1, 8'h03, 1}, '{0, 1, 0, 1, 3'h4, 8'h03, 0},
             '{1, 0, 1, 0, 3'h2, 8'h05, 0}};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 7; k++) begin
      i_host.wr(A_SEN, {5'h00, rows[k].en}, r);
      {sb_wr, sb_rd, sb_full, sb_empty} <= rows[k][15:12];
      @(posedge clk);
      {sb_wr, sb_rd} <= 2'h0;
      #1;
      `E1RI_CHK(frm_del, rows[k].wr & rows[k].full)
      `E1RI_CHK(frm_rep, rows[k].rd & rows[k].empty)
      `E1RI_CHK(irq, rows[k].irq)
      @(posedge clk);
      i_host.rd(A_SSTS, d, r);
      `E1RI_CHK(d, {24'h00_0000, rows[k].sts})
      i_host.rd(A_SSTS, d, r);
      `E1RI_CHK(d, 32'h0000_0000)
      `E1RI_CHK(irq, 1'b0)
    end
    // enable keeps its three bits; status ignores writes
    i_host.wr(A_SEN, 8'hff, r);
    i_host.rd(A_SEN, d, r);
    `E1RI_CHK(d, 32'h0000_0007)
    i_host.wr(A_LSTS, 8'hff, r);
    `E1RI_CHK(r, `E1RI_RESP_OKAY)
    i_host.rd(A_LSTS, d, r);
    `E1RI_CHK(d, 32'h0000_0000)
    // pattern start and end both flag a change
    i_host.wr(A_LEN, 8'h40, r);
    alt <= 1'b1;
    repeat (3) @(posedge clk);
    `E1RI_CHK(irq, 1'b1)
    i_host.rd(A_LSTS, d, r);
    `E1RI_CHK(d, 32'h0000_00c0)
    i_host.rd(A_LSTS, d, r);
    `E1RI_CHK(d, 32'h0000_0080)
    alt <= 1'b0;
    repeat (3) @(posedge clk);
    i_host.rd(A_LSTS, d, r);
    `E1RI_CHK(d, 32'h0000_0040)
    // interworking: not before the limit, set after, cleared by lock
    i_host.wr(A_LEN, 8'h10, r);
    i_host.wr(A_FC, 8'h01, r);
    bfa <= 1'b1;
    repeat (12) @(posedge clk);
    i_host.rd(A_LSTS, d, r);
    `E1RI_CHK(d, 32'h0000_0000)
    repeat (14) @(posedge clk);
    `E1RI_CHK(irq, 1'b1)
    i_host.rd(A_LSTS, d, r);
    `E1RI_CHK(d, 32'h0000_0030)
    mf <= 1'b1;
    repeat (10) @(posedge clk);
    i_host.rd(A_LSTS, d, r);
    `E1RI_CHK(d, 32'h0000_0010)
    mf <= 1'b0;
    i_host.wr(A_FC, 8'h00, r);
    repeat (30) @(posedge clk);
    i_host.rd(A_LSTS, d, r);
    `E1RI_CHK(d, 32'h0000_0000)
    // unmapped place answers with an error
    i_host.rd(16'h0000, d, r);
    `E1RI_CHK(r, `E1RI_RESP_SLVERR)
    i_host.wr(16'h0000, 8'h01, r);
    `E1RI_CHK(r, `E1RI_RESP_SLVERR)
    // second reset returns enables to zero
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    i_host.rd(A_SEN, d, r);
    `E1RI_CHK(d, 32'h0000_0000)
    i_host.rd(A_LEN, d, r);
    `E1RI_CHK(d, 32'h0000_0000)
    `E1RI_CHK(irq, 1'b0)
    final_report();
  end
endmodule
`default_nettype wire
